// ==== common/lpmc_defines.svh ====
// constants for the low power mode controller
// assumes inclusion by bare name from the design file
`ifndef LPMC_DEFINES_SVH
`define LPMC_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_CTRL      12'h000
`define OFS_CFG       12'h004
`define OFS_ENTER     12'h008
`define OFS_STATUS    12'h00C
`define OFS_WAKE_CAUSE 12'h010

// ****************************************
// field positions
// ****************************************
`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   2
`define CTRL_LPRUN_BIT  3
`define CFG_STOPCLK_BIT 0
`define CFG_RETAIN_BIT  1
`define CFG_LSI_BIT     2
`define CFG_LSE_BIT     3
`define CFG_CSSL_BIT    4
`define CFG_RTC_BIT     5
`define CFG_WKPOL_BIT   6
`define CFG_PULL_LSB    8

// ****************************************
// reset values
// ****************************************
`define CTRL_RESET  32'h00000000
`define CFG_RESET   32'h00000000

// ****************************************
// clock figures in khz
// ****************************************
`define LPRUN_MAX_KHZ    2000
`define STOP_MSI_KHZ     48000
`define STANDBY_MSI_KHZ  8000
`define SHUTDOWN_MSI_KHZ 4000

`endif

// ==== common/lpmc_pkg.sv ====
// types for the low power mode controller
// assumes nothing of its surroundings
package lpmc_pkg;

  typedef enum logic [2:0] {
    SEL_STOP0    = 3'h0,
    SEL_STOP1    = 3'h1,
    SEL_STOP2    = 3'h2,
    SEL_STANDBY  = 3'h3,
    SEL_SHUTDOWN = 3'h4,
    SEL_SLEEP    = 3'h5
  } mode_sel_e;

  typedef enum logic [8:0] {
    ST_RUN      = 9'h001,
    ST_SLEEP    = 9'h002,
    ST_LPRUN    = 9'h004,
    ST_LPSLEEP  = 9'h008,
    ST_STOP0    = 9'h010,
    ST_STOP1    = 9'h020,
    ST_STOP2    = 9'h040,
    ST_STANDBY  = 9'h080,
    ST_SHUTDOWN = 9'h100
  } pstate_e;

  typedef struct packed {
    logic internal_16mhz_rc;
    logic multispeed_internal_rc;
    logic external_high_speed_crystal;
    logic pll;
    logic internal_low_speed_rc;
    logic external_low_speed_crystal;
  } osc_en_s;

  typedef struct packed {
    logic core_clk;
    logic domain_clk;
    logic core_power;
    logic main_regulator;
    logic low_power_regulator;
    logic main_sram_bank;
    logic retainable_sram_bank;
    logic reg_retain;
    logic brownout_monitor;
    logic supply_monitor;
    logic backup_switch;
  } pwr_ctl_s;

  typedef struct packed {
    logic external_reset_pin;
    logic independent_watchdog;
    logic wakeup_pin;
    logic rtc_event;
    logic clock_failure_monitor;
    logic irq;
  } wake_src_s;

endpackage : lpmc_pkg

// ==== src/low_power_mode_controller.sv ====
// power mode sequencer with apb registers
// assumes one clock, synchronous reset, wake inputs from pins or other domains
//
// How it works
// R1: reset always lands in run; low power modes only when software asks
// R2: sleep gates only the core clock; any irq or event wakes it
// R3: low power run uses low power regulator, core clock capped at 2 mhz
// R4: low power sleep only from low power run and returns there
// R5: stop gates domain clocks, disables fast oscillators, keeps low speed ones
// R6: stop retains both sram banks and registers; rtc optional
// R7: waking peripherals may switch the 16 mhz rc on during stop
// R8: stop0 keeps main regulator; stop1 and stop2 use low power regulator
// R9: stop exit clock is multispeed rc to 48 mhz or 16 mhz rc
// R10: standby powers core off and disables all fast oscillators
// R11: brownout monitor stays on throughout standby
// R12: standby holds each io at its selected pull state
// R13: standby loses main sram and non backup registers
// R14: retention keeps retainable sram on low power regulator in standby
// R15: standby exits on reset pin, watchdog, wake pin, rtc, crystal failure
// R16: after standby wake the multispeed rc runs at 8 mhz
// R17: shutdown powers core off and stops every oscillator but the crystal
// R18: shutdown has no brownout, supply monitoring or backup switching
// R19: shutdown loses both sram banks and all non backup registers
// R20: shutdown exits on reset pin, wake pin, rtc; then multispeed rc 4 mhz
// R21: low speed rc optional run through standby, never in shutdown
// R22: low speed crystal optional in every mode
// R23: crystal failure monitor optional run through standby, wakes stop and standby
// R24: core selects the target mode before issuing its entry request

`timescale 1ns/1ns
`default_nettype none
`include "lpmc_defines.svh"

module low_power_mode_controller
  import lpmc_pkg::*;
#(
  parameter int IO_COUNT = 5
)
(
  // clock and reset
  input  wire  logic                clk,
  input  wire  logic                rst,
  // apb slave
  input  wire  logic                psel,
  input  wire  logic                penable,
  input  wire  logic                pwrite,
  input  wire  logic [11:0]         paddr,
  input  wire  logic [31:0]         pwdata,
  output var   logic [31:0]         prdata,
  output var   logic                pready,
  output var   logic                pslverr,
  // core side
  input  wire  logic                wait_request,
  input  wire  logic                irq_event,
  input  wire  logic                periph_hsi_request,
  // wake sources and battery status from pins and other domains
  input  wire  logic                external_reset_pin_n,
  input  wire  logic                independent_watchdog_reset,
  input  wire  logic                wakeup_pin,
  input  wire  logic                rtc_event,
  input  wire  logic                clock_failure_monitor_event,
  input  wire  logic                battery_only,
  // power and clock controls
  output var   osc_en_s             osc_en,
  output var   pwr_ctl_s            pwr_ctl,
  output var   logic                clock_failure_monitor_en,
  output var   logic                rtc_en,
  output var   logic                sysclk_is_hsi,
  output var   logic [15:0]         msi_khz,
  output var   logic [2*IO_COUNT-1:0] io_pull,
  output var   logic                io_hold,
  output var   pstate_e             pstate
);

  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] sync3_reg;
  logic [NSYNC-1:0] clean_reg;
  logic [NSYNC-1:0] raw_in;
  logic             wkpin_prev_reg;

  assign raw_in = {~external_reset_pin_n, independent_watchdog_reset, wakeup_pin,
                   rtc_event, clock_failure_monitor_event, battery_only};

  always_ff @(posedge clk)
  begin
    sync1_reg <= raw_in;
    sync2_reg <= sync1_reg;
    sync3_reg <= sync2_reg;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      clean_reg <= '0;
    else
      for (int i = 0; i < NSYNC; i++)
        if (sync2_reg[i] == sync3_reg[i])
          clean_reg[i] <= sync3_reg[i];
  end

  logic rstpin_s;
  logic wdg_s;
  logic wkpin_s;
  logic rtc_s;
  logic cssl_s;
  logic vbat_s;
  assign {rstpin_s, wdg_s, wkpin_s, rtc_s, cssl_s, vbat_s} = clean_reg;

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ctrl_reg;
  logic [31:0] cfg_reg;
  logic [31:0] cause_reg;
  logic        enter_reg;
  logic        enter_next;

  logic        wr_en;
  logic        rd_en;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `OFS_CTRL) || (a == `OFS_CFG) || (a == `OFS_ENTER) ||
             (a == `OFS_STATUS) || (a == `OFS_WAKE_CAUSE);
  endfunction : mapped

  logic wake_sd;
  logic lp_power_off;
  assign lp_power_off = (pstate == ST_STANDBY) || (pstate == ST_SHUTDOWN);

  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_reg <= `CTRL_RESET;
    else if (lp_power_off)
      ctrl_reg <= `CTRL_RESET; // R13
    else if (wr_en && paddr == `OFS_CTRL)
      ctrl_reg <= {28'h0000000, pwdata[3:0]};
  end

  // pull selection lives with standby circuitry and survives standby
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg_reg <= `CFG_RESET;
    else if (pstate == ST_SHUTDOWN && wake_sd)
      cfg_reg <= `CFG_RESET; // R19
    else if (wr_en && paddr == `OFS_CFG && !lp_power_off)
      cfg_reg <= pwdata & {{(24-2*IO_COUNT){1'b0}}, {(2*IO_COUNT){1'b1}}, 8'h7F};
  end

  assign enter_next = wr_en && paddr == `OFS_ENTER && pwdata[0];

  always_ff @(posedge clk)
  begin
    if (rst)
      enter_reg <= 1'b0;
    else
      enter_reg <= enter_next;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      prdata  <= 32'h00000000;
      if (psel && !penable && !pwrite)
        case (paddr)
          `OFS_CTRL:       prdata <= ctrl_reg;
          `OFS_CFG:        prdata <= cfg_reg;
          `OFS_STATUS:     prdata <= {23'h000000, pstate};
          `OFS_WAKE_CAUSE: prdata <= cause_reg;
          default:         prdata <= 32'h00000000;
        endcase
    end
  end

  // ****************************************
  // mode sequencer
  // ****************************************
  logic     entry;
  logic     wake_stop;
  logic     wake_sb;
  logic     wkpin_edge;
  pstate_e  pstate_next;
  mode_sel_e sel;

  assign sel = mode_sel_e'(ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
  assign entry = wait_request | enter_reg; // R24
  assign wkpin_edge = cfg_reg[`CFG_WKPOL_BIT] ? (wkpin_prev_reg & ~wkpin_s)
                                              : (~wkpin_prev_reg & wkpin_s);
  assign wake_stop = irq_event | rstpin_s | rtc_s | wkpin_edge |
                     (cssl_s & cfg_reg[`CFG_CSSL_BIT]); // R23
  assign wake_sb = rstpin_s | wdg_s | wkpin_edge | rtc_s |
                   (cssl_s & cfg_reg[`CFG_CSSL_BIT]); // R15
  assign wake_sd = rstpin_s | wkpin_edge | rtc_s; // R20

  always_ff @(posedge clk)
  begin
    if (rst)
      wkpin_prev_reg <= 1'b0;
    else
      wkpin_prev_reg <= wkpin_s;
  end

  always_comb
  begin
    pstate_next = pstate;
    case (pstate)
      ST_RUN, ST_LPRUN:
        if (ctrl_reg[`CTRL_LPRUN_BIT] && pstate == ST_RUN)
          pstate_next = ST_LPRUN; // R3
        else if (!ctrl_reg[`CTRL_LPRUN_BIT] && pstate == ST_LPRUN)
          pstate_next = ST_RUN;
        else if (entry)
          case (sel)
            SEL_SLEEP:    pstate_next = (pstate == ST_LPRUN) ? ST_LPSLEEP : ST_SLEEP; // R4
            SEL_STOP0:    pstate_next = ST_STOP0;
            SEL_STOP1:    pstate_next = ST_STOP1;
            SEL_STOP2:    pstate_next = ST_STOP2;
            SEL_STANDBY:  pstate_next = ST_STANDBY;
            SEL_SHUTDOWN: pstate_next = ST_SHUTDOWN;
            default:      pstate_next = pstate;
          endcase
      ST_SLEEP:
        if (irq_event)
          pstate_next = ST_RUN; // R2
      ST_LPSLEEP:
        if (irq_event)
          pstate_next = ST_LPRUN; // R4
      ST_STOP0, ST_STOP1, ST_STOP2:
        if (wake_stop)
          pstate_next = ST_RUN;
      ST_STANDBY:
        if (wake_sb)
          pstate_next = ST_RUN;
      ST_SHUTDOWN:
        if (wake_sd)
          pstate_next = ST_RUN;
      default:
        pstate_next = ST_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pstate <= ST_RUN; // R1
    else
      pstate <= pstate_next;
  end

  logic [1:0] exit_kind_reg;  // 0 none, 1 stop, 2 standby, 3 shutdown

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      exit_kind_reg <= 2'h0;
      cause_reg     <= 32'h00000000;
    end
    else if (pstate != ST_RUN && pstate_next == ST_RUN &&
             pstate != ST_SLEEP && pstate != ST_LPRUN)
    begin
      exit_kind_reg <= (pstate == ST_STANDBY) ? 2'h2 :
                       (pstate == ST_SHUTDOWN) ? 2'h3 : 2'h1;
      cause_reg <= {26'h0000000, rstpin_s, wdg_s, wkpin_edge, rtc_s, cssl_s, irq_event};
    end
  end

  // ****************************************
  // power and clock outputs
  // ****************************************
  logic in_stop;
  logic in_sb;
  logic in_sd;
  assign in_stop = (pstate == ST_STOP0) || (pstate == ST_STOP1) || (pstate == ST_STOP2);
  assign in_sb   = pstate == ST_STANDBY;
  assign in_sd   = pstate == ST_SHUTDOWN;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      osc_en  <= '0;
      pwr_ctl <= '0;
      clock_failure_monitor_en <= 1'b0;
      rtc_en  <= 1'b0;
      io_hold <= 1'b0;
      io_pull <= '0;
    end
    else
    begin
      osc_en.internal_16mhz_rc <= !(in_stop || in_sb || in_sd) ||
                                  (in_stop && periph_hsi_request); // R5 R7 R10 R17
      osc_en.multispeed_internal_rc      <= !(in_stop || in_sb || in_sd); // R5 R10 R17
      osc_en.external_high_speed_crystal <= 1'b0;
      osc_en.pll <= !(in_stop || in_sb || in_sd) && pstate != ST_LPRUN &&
                    pstate != ST_LPSLEEP;
      osc_en.internal_low_speed_rc <= cfg_reg[`CFG_LSI_BIT] && !in_sd && !vbat_s; // R21
      osc_en.external_low_speed_crystal <= cfg_reg[`CFG_LSE_BIT]; // R22
      pwr_ctl.core_clk   <= pstate == ST_RUN || pstate == ST_LPRUN; // R2 R4
      pwr_ctl.domain_clk <= !(in_stop || in_sb || in_sd); // R5
      pwr_ctl.core_power <= !(in_sb || in_sd); // R10 R17
      pwr_ctl.main_regulator <= !(in_sb || in_sd) && pstate != ST_LPRUN &&
                                pstate != ST_LPSLEEP && pstate != ST_STOP1 &&
                                pstate != ST_STOP2; // R3 R8
      pwr_ctl.low_power_regulator <= pstate == ST_LPRUN || pstate == ST_LPSLEEP ||
                                     pstate == ST_STOP1 || pstate == ST_STOP2 ||
                                     (in_sb && cfg_reg[`CFG_RETAIN_BIT]); // R8 R14
      pwr_ctl.main_sram_bank <= !(in_sb || in_sd); // R6 R13 R19
      pwr_ctl.retainable_sram_bank <= !(in_sb || in_sd) ||
                                      (in_sb && cfg_reg[`CFG_RETAIN_BIT]); // R14
      pwr_ctl.reg_retain <= !(in_sb || in_sd); // R6 R13
      pwr_ctl.brownout_monitor <= !in_sd; // R11 R18
      pwr_ctl.supply_monitor   <= !in_sd; // R18
      pwr_ctl.backup_switch    <= !in_sd; // R18
      clock_failure_monitor_en <= cfg_reg[`CFG_CSSL_BIT] && !in_sd; // R23
      rtc_en  <= cfg_reg[`CFG_RTC_BIT]; // R6
      io_hold <= in_sb || in_sd; // R12
      io_pull <= cfg_reg[`CFG_PULL_LSB +: 2*IO_COUNT]; // R12
    end
  end

  // system clock choice after each kind of exit
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sysclk_is_hsi <= 1'b0;
      msi_khz       <= 16'(`SHUTDOWN_MSI_KHZ);
    end
    else if (pstate == ST_LPRUN || pstate == ST_LPSLEEP)
    begin
      sysclk_is_hsi <= 1'b0;
      msi_khz       <= 16'(`LPRUN_MAX_KHZ); // R3
    end
    else
      case (exit_kind_reg)
        2'h1:
        begin
          sysclk_is_hsi <= cfg_reg[`CFG_STOPCLK_BIT]; // R9
          msi_khz       <= 16'(`STOP_MSI_KHZ);
        end
        2'h2:
        begin
          sysclk_is_hsi <= 1'b0;
          msi_khz       <= 16'(`STANDBY_MSI_KHZ); // R16
        end
        2'h3:
        begin
          sysclk_is_hsi <= 1'b0;
          msi_khz       <= 16'(`SHUTDOWN_MSI_KHZ); // R20
        end
        default:
        begin
          sysclk_is_hsi <= 1'b0;
          msi_khz       <= 16'(`SHUTDOWN_MSI_KHZ);
        end
      endcase
  end

endmodule : low_power_mode_controller

`default_nettype wire

// ==== verification/core_model.sv ====
// processor core model raising entry and wake requests
// assumes the bench calls its tasks right after a rising edge
`timescale 1ns/1ns
`default_nettype none
module core_model
  import lpmc_pkg::*;
(
  // clock and state
  input  wire logic    clk,
  input  wire pstate_e pstate,
  // requests
  output var  logic    wait_request,
  output var  logic    irq_event
);
  initial wait_request = 1'b0;
  initial irq_event = 1'b0;
  // mode is written by the bench before this call
  task enter;
    wait_request <= 1'b1;
    @(posedge clk);
    wait_request <= 1'b0;
    @(posedge clk);
  endtask : enter
  // holds the event until the state moves or 40 cycles pass
  task irq(input int dly);
    pstate_e s;
    repeat (dly) @(posedge clk);
    s = pstate;
    irq_event <= 1'b1;
    for (int i = 0; i < 40 && pstate == s; i++) @(posedge clk);
    irq_event <= 1'b0;
  endtask : irq
endmodule : core_model
`default_nettype wire

// ==== verification/low_power_mode_controller_tb_top.sv ====
// self-checking bench for the power mode controller
// assumes checker and core model compiled before it
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", n, e, s); end end
module low_power_mode_controller_tb_top;
  import lpmc_pkg::*;
  typedef struct packed {pstate_e st; logic [15:0] khz; logic [1:0] hsi;} note_s;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, wait_request, irq_event;
  logic hsi_req, rpin_n, wdg, wkpin, rtc, cssl, batt, cfm_en, rtc_en, hsi, io_hold, pend;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cfg;
  logic [15:0] khz;
  logic [9:0]  io_pull;
  logic [32:0] r;
  osc_en_s     osc_en;
  pwr_ctl_s    pwr_ctl;
  pstate_e     pstate, ps;
  note_s       qs[$], n;
  logic [32:0] qr[$];
  int          mismatches, samples_checked;
  core_model core (.clk(clk), .pstate(pstate), .wait_request(wait_request),
    .irq_event(irq_event));
  low_power_mode_controller #(.IO_COUNT(5)) uut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wait_request(wait_request), .irq_event(irq_event),
    .periph_hsi_request(hsi_req), .external_reset_pin_n(rpin_n),
    .independent_watchdog_reset(wdg), .wakeup_pin(wkpin), .rtc_event(rtc),
    .clock_failure_monitor_event(cssl), .battery_only(batt), .osc_en(osc_en),
    .pwr_ctl(pwr_ctl), .clock_failure_monitor_en(cfm_en), .rtc_en(rtc_en),
    .sysclk_is_hsi(hsi), .msi_khz(khz), .io_pull(io_pull), .io_hold(io_hold),
    .pstate(pstate));
  // ****
  // tasks
  // ****
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task tmo(input string s);
    mismatches++;
    $display("ERROR %s wait timed out", s);
    stop_test();
  endtask : tmo
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k == 16) tmo("apb");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task rd(input logic [11:0] a, input logic [32:0] e);
    qr.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task note(input pstate_e s, input logic [15:0] k, input logic [1:0] h);
    qs.push_back({s, k, h});
  endtask : note
  task wst(input pstate_e s);
    int k;
    for (k = 0; k < 60 && pstate !== s; k++) @(posedge clk);
    if (k == 60) tmo("state");
  endtask : wst
  // ****
  // monitor
  // ****
  initial
  begin
    pend = 1'b0;
    ps = ST_RUN;
    forever
    begin
      @(negedge clk);
      if (pend)
      begin
        if (n.khz != 16'h0) `CHK("msi khz", n.khz, khz)
        if (n.hsi[1]) `CHK("hsi select", n.hsi[0], hsi)
        pend = 1'b0;
      end
      if (psel && penable && pready && !pwrite)
      begin
        r = qr.pop_front();
        `CHK("read", r, {pslverr, prdata})
      end
      if (!rst && pstate !== ps)
      begin
        ps = pstate;
        n = qs.pop_front();
        pend = 1'b1;
        `CHK("state", n.st, ps)
      end
    end
  end
  // ****
  // main sequence
  // ****
  initial
  begin
    {rst, rpin_n} = 2'b11;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {hsi_req, wdg, wkpin, rtc, cssl, batt} = '0;
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(41714));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(12'h000, 33'h0);
    rd(12'h00C, {24'h0, ST_RUN});
    rd(12'h020, 33'h100000000);
    $display("test reset done");
    apb(1'b1, 12'h000, 32'h5);
    note(ST_SLEEP, 16'h0, 2'h0);
    core.enter();
    wst(ST_SLEEP);
    note(ST_RUN, 16'h0, 2'h0);
    core.irq(0);
    wst(ST_RUN);
    $display("test sleep done");
    for (int i = 0; i < 3; i++)
    begin
      cfg = 32'($urandom % 2);
      apb(1'b1, 12'h004, cfg);
      apb(1'b1, 12'h000, 32'(i));
      note(pstate_e'(9'h010 << i), 16'h0, 2'h0);
      core.enter();
      hsi_req <= 1'b1;
      wst(pstate_e'(9'h010 << i));
      repeat (4) @(posedge clk);
      hsi_req <= 1'b0;
      note(ST_RUN, 16'hBB80, {1'b1, cfg[0]});
      if (i == 0) core.irq($urandom % 8);
      rtc <= (i == 1);
      rpin_n <= (i != 2);
      wst(ST_RUN);
      rtc <= 1'b0;
      rpin_n <= 1'b1;
    end
    $display("test stop done");
    note(ST_LPRUN, 16'h07D0, 2'h0);
    apb(1'b1, 12'h000, 32'hD);
    wst(ST_LPRUN);
    note(ST_LPSLEEP, 16'h0, 2'h0);
    apb(1'b1, 12'h008, 32'h1);
    wst(ST_LPSLEEP);
    note(ST_LPRUN, 16'h07D0, 2'h0);
    core.irq(3);
    wst(ST_LPRUN);
    $display("test lprun done");
    cfg = {14'h0, 10'($urandom), 8'h26};
    apb(1'b1, 12'h004, cfg);
    apb(1'b1, 12'h000, 32'hB);
    note(ST_STANDBY, 16'h0, 2'h0);
    core.enter();
    wst(ST_STANDBY);
    repeat (2) @(posedge clk);
    `CHK("io pull", cfg[17:8], io_pull)
    `CHK("retain", 2'b11, {pwr_ctl.retainable_sram_bank, pwr_ctl.low_power_regulator})
    `CHK("rtc lsi", 2'b11, {rtc_en, osc_en.internal_low_speed_rc})
    batt <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("lsi battery", 1'b0, osc_en.internal_low_speed_rc)
    batt <= 1'b0;
    note(ST_RUN, 16'h1F40, 2'h0);
    wdg <= 1'b1;
    wst(ST_RUN);
    wdg <= 1'b0;
    rd(12'h000, 33'h0);
    $display("test standby done");
    apb(1'b1, 12'h000, 32'h4);
    note(ST_SHUTDOWN, 16'h0, 2'h0);
    core.enter();
    wst(ST_SHUTDOWN);
    wdg <= 1'b1;
    repeat (10) @(posedge clk);
    wdg <= 1'b0;
    rd(12'h00C, {24'h0, ST_SHUTDOWN});
    note(ST_RUN, 16'h0FA0, 2'h0);
    wkpin <= 1'b1;
    wst(ST_RUN);
    wkpin <= 1'b0;
    rd(12'h004, 33'h0);
    $display("test shutdown done");
    apb(1'b1, 12'h000, 32'h5);
    note(ST_SLEEP, 16'h0, 2'h0);
    core.enter();
    wst(ST_SLEEP);
    note(ST_RUN, 16'h0, 2'h0);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(12'h000, 33'h0);
    $display("test reset again done");
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule : low_power_mode_controller_tb_top
`default_nettype wire

// ==== verification/lpmc_checker.sv ====
// port assertions for the power mode controller
// assumes a bind onto low_power_mode_controller
`timescale 1ns/1ns
`default_nettype none
module lpmc_checker
  import lpmc_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // observed ports
  input wire logic        periph_hsi_request,
  input wire osc_en_s     osc_en,
  input wire pwr_ctl_s    pwr_ctl,
  input wire logic        clock_failure_monitor_en,
  input wire logic [15:0] msi_khz,
  input wire logic        io_hold,
  input wire pstate_e     pstate
);
  // ****
  // assertions
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic stp;
  assign stp = pstate inside {ST_STOP0, ST_STOP1, ST_STOP2};
  chk_reset_run: assert property (disable iff (1'b0) rst |=> pstate == ST_RUN)
    else $error("state not run after reset");
  chk_sleep_core: assert property (pstate == ST_SLEEP |=>
    !pwr_ctl.core_clk && pwr_ctl.domain_clk) else $error("sleep clock gating wrong");
  chk_lprun_limit: assert property (pstate == ST_LPRUN |=>
    pwr_ctl.low_power_regulator && msi_khz == 16'h07D0) else $error("lprun supply wrong");
  chk_lpsleep_source: assert property (pstate == ST_LPSLEEP |->
    $past(pstate) inside {ST_LPRUN, ST_LPSLEEP}) else $error("lpsleep bad source");
  chk_stop_clocks: assert property (stp |=> !pwr_ctl.domain_clk && !osc_en.pll
    && !osc_en.multispeed_internal_rc && !osc_en.external_high_speed_crystal
    && pwr_ctl.main_sram_bank && pwr_ctl.reg_retain) else $error("stop outputs wrong");
  chk_stop_hsi: assert property (stp && periph_hsi_request ##1
    stp && periph_hsi_request |=> osc_en.internal_16mhz_rc) else $error("hsi not lent");
  chk_stop_regulator: assert property (stp |=>
    pwr_ctl.main_regulator == ($past(pstate) == ST_STOP0)) else $error("stop regulator");
  chk_stop_exit: assert property (pstate == ST_RUN && $past(stp) |=>
    msi_khz == 16'hBB80) else $error("stop exit clock wrong");
  chk_standby_power: assert property (pstate == ST_STANDBY |=>
    !pwr_ctl.core_power && pwr_ctl.brownout_monitor && !pwr_ctl.main_sram_bank
    && io_hold && !osc_en.pll && !osc_en.internal_16mhz_rc) else $error("standby wrong");
  chk_standby_exit: assert property (pstate == ST_RUN && $past(pstate) == ST_STANDBY
    |=> msi_khz == 16'h1F40) else $error("standby exit clock wrong");
  chk_shutdown_off: assert property (pstate == ST_SHUTDOWN |=>
    !pwr_ctl.brownout_monitor && !pwr_ctl.supply_monitor && !pwr_ctl.backup_switch
    && !pwr_ctl.retainable_sram_bank && !osc_en.internal_low_speed_rc
    && !clock_failure_monitor_en) else $error("shutdown outputs wrong");
  chk_shutdown_exit: assert property (pstate == ST_RUN && $past(pstate) == ST_SHUTDOWN
    |=> msi_khz == 16'h0FA0) else $error("shutdown exit clock wrong");
  cover property (pstate == ST_LPSLEEP);
  cover property (pstate == ST_STANDBY);
  cover property (pstate == ST_SHUTDOWN);
endmodule : lpmc_checker
bind low_power_mode_controller lpmc_checker chk (.clk(clk), .rst(rst),
  .periph_hsi_request(periph_hsi_request), .osc_en(osc_en), .pwr_ctl(pwr_ctl),
  .clock_failure_monitor_en(clock_failure_monitor_en), .msi_khz(msi_khz),
  .io_hold(io_hold), .pstate(pstate));
`default_nettype wire
